// File: bel_cfg.svh
// Offsets, field positions, reset values and counts of the error logger
`ifndef BEL_CFG_SVH
`define BEL_CFG_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BEL_OFS_STAT_LO 8'h00
`define BEL_OFS_STAT_HI 8'h04
`define BEL_OFS_IRQ_STAT 8'h08
`define BEL_OFS_IRQ_MASK 8'h0C
`define BEL_OFS_CTRL 8'h10
`define BEL_OFS_STALL 8'h14
// ****************************************
// Status field positions (64-bit view)
// ****************************************
`define BEL_POS_RTYPE 19
`define BEL_POS_TIMEOUT 38
`define BEL_POS_HARD 42
`define BEL_POS_INTFAIL 43
`define BEL_POS_PARITY 44
`define BEL_POS_UNCORR 45
`define BEL_POS_CORR 46
`define BEL_POS_SYND 47
`define BEL_POS_VALID 57
// ****************************************
// Reset values and counts
// ****************************************
`define BEL_RST_CTRL 2'h0
`define BEL_RST_MASK 6'h00
`define BEL_PARITY_LIMIT 2'h2
`define BEL_BUS_DIV 128
`define BEL_PRE_BITS 8
`define BEL_STALL_BITS 15
`endif

// File: bel_logger.sv
// Bus error status logger with stall timeout and register port
// Functional notes
// - The prescale timer is 8 bits and steps once per 128 bus clocks.
// - Each carry out of the prescale timer adds one to the stall counter.
// - The bus clock runs at one half, third or quarter of the core clock.
// - The timeout bit, once set, stays set whatever is logged later.
// - Status bit 42 sets on a hard error response and is held.
// - Status bit 43 sets when the internal failure pin goes active, held.
// - Status bit 44 sets after two address parity failures, held.
// - Status bit 45 sets on an uncorrectable ECC error and freezes syndrome.
// - Status bit 46 sets on every corrected single ECC error.
// - Syndrome bits 47-54 load on an ECC error only while bit 45 is clear.
// - Validity indicators sit in status bits 62 and 63.
// - Error code bits 0-15 hold the form 0000 1PPT RRRR IILL.
// - Bits 19-24 hold the six-bit request class of the failing access.
// - Bit 38 sets when the 15-bit stall counter carries out of its top.
// - The stall counter clears on retire, exception, reset or reinit.
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "bel_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module bel_logger #(
	parameter int BUS_DIV = `BEL_BUS_DIV,
	parameter int PRE_BITS = `BEL_PRE_BITS,
	parameter int STALL_BITS = `BEL_STALL_BITS
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic retire_i,
	input wire logic exception_i,
	input wire logic internal_failure_pin_i,
	input wire bel_pkg::bel_err_ev_t err_ev_i,
	input wire bel_pkg::bel_err_info_t err_info_i,
	output logic bus_clk_o,
	output logic bus_reinit_signal_o,
	output logic irq_o
);
	localparam int DIVW = $clog2(BUS_DIV);
	// ****************************************
	// Register port decode
	// ****************************************
	wire logic wr_lo = wr_i && (addr_i == `BEL_OFS_STAT_LO);
	wire logic wr_hi = wr_i && (addr_i == `BEL_OFS_STAT_HI);
	wire logic wr_mask = wr_i && (addr_i == `BEL_OFS_IRQ_MASK);
	wire logic wr_ctrl = wr_i && (addr_i == `BEL_OFS_CTRL);
	wire logic rd_irq = rd_i && (addr_i == `BEL_OFS_IRQ_STAT);
	// Write-zero-to-clear masks; all ones when no write hits the word
	wire logic [31:0] keep_lo = wr_lo ? wdata_i : 32'hFFFFFFFF;
	wire logic [31:0] keep_hi = wr_hi ? wdata_i : 32'hFFFFFFFF;
	wire logic [63:0] keep = {keep_hi, keep_lo};

	// ****************************************
	// Bus clock derived from core clock
	// ****************************************
	logic [1:0] ratio;
	logic [1:0] bdiv;
	// Unused encoding falls back to the slowest ratio
	wire logic [1:0] bdiv_last = (ratio == bel_pkg::BEL_DIV2) ? 2'h1 :
		(ratio == bel_pkg::BEL_DIV3) ? 2'h2 : 2'h3;
	wire logic bus_tick = (bdiv == 2'h0);
	wire logic [1:0] next_bdiv = (bdiv >= bdiv_last) ? 2'h0 : bdiv + 2'h1;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bdiv <= 2'h0;
			bus_clk_o <= 1'b0;
		end else begin
			bdiv <= next_bdiv;
			bus_clk_o <= (next_bdiv <= (bdiv_last >> 1));
		end
	end

	// ****************************************
	// Prescaler and stall counter
	// ****************************************
	logic [DIVW-1:0] bcnt;
	logic [PRE_BITS-1:0] ptimer;
	logic [STALL_BITS-1:0] stall_cnt;
	wire logic pre_tick = bus_tick && (bcnt == DIVW'(BUS_DIV - 1));
	wire logic pre_carry = pre_tick && (&ptimer);
	wire logic stall_carry = pre_carry && (&stall_cnt);
	// Reinit pulse is the timeout itself, one cycle late
	wire logic stall_clr = retire_i || exception_i || bus_reinit_signal_o;
	// Bus cycle divider then the 8-bit prescale timer
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bcnt <= '0;
			ptimer <= '0;
		end else begin
			if (bus_tick) begin
				bcnt <= pre_tick ? '0 : bcnt + 1'b1;
			end
			if (pre_tick) begin
				ptimer <= ptimer + 1'b1;
			end
		end
	end
	// Clearing beats counting: retirement means no stall
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stall_cnt <= '0;
			bus_reinit_signal_o <= 1'b0;
		end else begin
			bus_reinit_signal_o <= stall_carry;
			if (stall_clr) begin
				stall_cnt <= '0;
			end else if (pre_carry) begin
				stall_cnt <= stall_cnt + 1'b1;
			end
		end
	end

	// ****************************************
	// Pin synchroniser and event shaping
	// ****************************************
	logic int_fail_s1, int_fail_s2, int_fail_s3;
	// Two stages against metastability, the third only finds the edge
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			int_fail_s1 <= 1'b0;
			int_fail_s2 <= 1'b0;
			int_fail_s3 <= 1'b0;
		end else begin
			int_fail_s1 <= internal_failure_pin_i;
			int_fail_s2 <= int_fail_s1;
			int_fail_s3 <= int_fail_s2;
		end
	end
	// A pin held high logs once, not every cycle
	wire logic int_fail_ev = int_fail_s2 && !int_fail_s3;
	// Second address parity failure raises the flag
	logic [1:0] parity_cnt;
	wire logic parity_ev = err_ev_i.parity_fail &&
		(parity_cnt == `BEL_PARITY_LIMIT - 2'h1);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			parity_cnt <= 2'h0;
		end else if (err_ev_i.parity_fail) begin
			parity_cnt <= parity_ev ? 2'h0 : parity_cnt + 2'h1;
		end
	end

	// ****************************************
	// Status register fields
	// ****************************************
	logic [15:0] ecode;
	logic [5:0] rtype;
	logic tmo, hard, int_fail, parity, ecc_uncorr, ecc_corr, valid, ovf;
	logic [7:0] synd;
	wire logic any_ev = err_ev_i.hard || parity_ev ||
		err_ev_i.ecc_uncorr || err_ev_i.ecc_corr || int_fail_ev ||
		stall_carry;
	// First error since the last clear owns the code fields
	wire logic load_code = any_ev && !valid;
	wire logic [15:0] next_ecode = load_code ?
		{4'h0, 1'b1, err_info_i.part, err_info_i.tmo, err_info_i.req,
		err_info_i.io, err_info_i.lvl} : ecode & keep[15:0];
	wire logic [5:0] next_rtype = load_code ? err_info_i.rtype :
		rtype & keep[`BEL_POS_RTYPE +: 6];
	// A live uncorrectable flag freezes the syndrome
	wire logic load_synd = (err_ev_i.ecc_uncorr || err_ev_i.ecc_corr) &&
		!ecc_uncorr;
	wire logic [7:0] next_synd = load_synd ? err_info_i.synd :
		synd & keep[`BEL_POS_SYND +: 8];
	// Sticky bits: a set in the clearing cycle wins
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ecode <= 16'h0000;
			rtype <= 6'h00;
			synd <= 8'h00;
			{tmo, hard, int_fail, parity, ecc_uncorr, ecc_corr, valid,
				ovf} <= 8'h00;
		end else begin
			ecode <= next_ecode;
			rtype <= next_rtype;
			synd <= next_synd;
			tmo <= stall_carry || (tmo && keep[`BEL_POS_TIMEOUT]);
			hard <= err_ev_i.hard || (hard && keep[`BEL_POS_HARD]);
			int_fail <= int_fail_ev ||
				(int_fail && keep[`BEL_POS_INTFAIL]);
			parity <= parity_ev ||
				(parity && keep[`BEL_POS_PARITY]);
			ecc_uncorr <= err_ev_i.ecc_uncorr ||
				(ecc_uncorr && keep[`BEL_POS_UNCORR]);
			ecc_corr <= err_ev_i.ecc_corr ||
				(ecc_corr && keep[`BEL_POS_CORR]);
			valid <= any_ev || (valid && keep[63]);
			ovf <= (any_ev && valid) || (ovf && keep[62]);
		end
	end
	// Assembled view; reserved bits read as zero
	wire logic [63:0] status = {valid, ovf, 5'h00, 2'h0, synd, ecc_corr,
		ecc_uncorr, parity, int_fail, hard, 3'h0, tmo, 13'h0000, rtype,
		3'h0, ecode};

	// ****************************************
	// Interrupt status, mask and control
	// ****************************************
	logic [5:0] irq_stat, irq_mask;
	wire logic [5:0] irq_ev = {stall_carry, err_ev_i.hard, int_fail_ev,
		parity_ev, err_ev_i.ecc_uncorr, err_ev_i.ecc_corr};
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat <= 6'h00;
			irq_mask <= `BEL_RST_MASK;
			ratio <= `BEL_RST_CTRL;
		end else begin
			irq_stat <= irq_ev | (rd_irq ? 6'h00 : irq_stat);
			if (wr_mask) begin
				irq_mask <= wdata_i[5:0];
			end
			if (wr_ctrl) begin
				ratio <= wdata_i[1:0];
			end
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// ****************************************
	// Read data, one cycle after the strobe
	// ****************************************
	wire logic [31:0] rd_mux =
		(addr_i == `BEL_OFS_STAT_LO) ? status[31:0] :
		(addr_i == `BEL_OFS_STAT_HI) ? status[63:32] :
		(addr_i == `BEL_OFS_IRQ_STAT) ? {26'h0, irq_stat} :
		(addr_i == `BEL_OFS_IRQ_MASK) ? {26'h0, irq_mask} :
		(addr_i == `BEL_OFS_CTRL) ? {30'h0, ratio} :
		(addr_i == `BEL_OFS_STALL) ? 32'(stall_cnt) : 32'h00000000;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h00000000;
		end else begin
			rdata_o <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_prescale_step: assert property (pre_tick |=>
		ptimer == $past(ptimer) + 1'b1)
		else $error("prescale timer did not step");
	a_prescale_hold: assert property (!pre_tick |=>
		$stable(ptimer))
		else $error("prescale timer moved without a tick");
	a_stall_incr: assert property (pre_carry && !stall_clr |=>
		stall_cnt == $past(stall_cnt) + 1'b1)
		else $error("stall counter missed a carry");
	a_bus_tick_gap: assert property (bus_tick |=> !bus_tick)
		else $error("bus clock faster than half core clock");
	a_timeout_set: assert property (stall_carry |=> tmo &&
		bus_reinit_signal_o ##1 stall_cnt == '0)
		else $error("timeout not logged or counter not cleared");
	a_timeout_hold: assert property (tmo && !wr_hi |=> tmo)
		else $error("timeout bit lost");
	a_hard_set: assert property (err_ev_i.hard |=> hard)
		else $error("hard error not logged");
	a_fail_pin_set: assert property ($rose(int_fail_s2) |=>
		int_fail)
		else $error("internal failure not logged");
	a_parity_two: assert property ($rose(parity) |->
		$past(parity_cnt) == 2'h1 && $past(err_ev_i.parity_fail))
		else $error("parity flag set before two failures");
	a_synd_frozen: assert property (ecc_uncorr && !wr_hi |=>
		$stable(synd))
		else $error("syndrome overwritten while frozen");
	a_corr_set: assert property (err_ev_i.ecc_corr |=>
		ecc_corr)
		else $error("corrected error not logged");
	a_synd_load: assert property (err_ev_i.ecc_corr &&
		!ecc_uncorr |=> synd == $past(err_info_i.synd))
		else $error("syndrome not captured");

	// Held flags and the uncorrectable set: without a write to the upper word nothing drops
	a_hard_hold: assert property (hard && !wr_hi |=> hard)
		else $error("hard error bit lost");
	a_fail_pin_hold: assert property (int_fail && !wr_hi |=>
		int_fail)
		else $error("internal failure bit lost");
	a_parity_hold: assert property (parity && !wr_hi |=>
		parity)
		else $error("parity flag lost");
	a_uncorr_set: assert property (err_ev_i.ecc_uncorr |=>
		ecc_uncorr)
		else $error("uncorrectable error not logged");
	a_corr_hold: assert property (ecc_corr && !wr_hi |=>
		ecc_corr)
		else $error("corrected error bit lost");
	// Syndrome only moves on an ECC event or a software write
	a_synd_quiet: assert property (!err_ev_i.ecc_uncorr &&
		!err_ev_i.ecc_corr && !wr_hi |=> $stable(synd))
		else $error("syndrome changed with no ECC event");

	// Validity and code ownership by the first error
	a_valid_set: assert property (any_ev |=> valid)
		else $error("valid bit not set by an error");
	a_code_held: assert property (valid && !wr_lo |=>
		$stable(rtype) && $stable(ecode))
		else $error("code fields replaced by a later error");

	// Timeout side effects and the ratio write
	a_prescale_wrap: assert property (pre_carry |=>
		ptimer == '0)
		else $error("prescale timer did not wrap on carry");
	a_reinit_pulse: assert property (bus_reinit_signal_o |=>
		!bus_reinit_signal_o)
		else $error("reinit pulse longer than one cycle");
	a_ratio_write: assert property (wr_ctrl |=>
		ratio == $past(wdata_i[1:0]))
		else $error("ratio write not taken");

	// Interrupt side, read port, code form, stall clear and write-zero clear
	a_irq_clear: assert property (rd_irq && irq_ev == 6'h00 |=>
		irq_stat == 6'h00)
		else $error("interrupt status not cleared by read");
	a_mask_write: assert property (wr_mask |=>
		irq_mask == $past(wdata_i[5:0]))
		else $error("interrupt mask write not taken");
	a_rdata_idle: assert property (!rd_i |=>
		rdata_o == 32'h00000000)
		else $error("read data not zero outside a read");
	a_code_form: assert property ($rose(valid) |->
		ecode[15:11] == 5'h01 && rtype == $past(err_info_i.rtype))
		else $error("error code form wrong");
	a_stall_clear: assert property (retire_i || exception_i |=>
		stall_cnt == '0)
		else $error("stall counter not cleared");
	a_clear_zero: assert property (hard && wr_hi &&
		!wdata_i[`BEL_POS_HARD - 32] && !err_ev_i.hard |=> !hard)
		else $error("write of zero did not clear");
endmodule
`default_nettype wire

// File: bel_pkg.sv
// Types shared by the bus error logger
package bel_pkg;
	// Details that travel with each reported bus error
	typedef struct packed {
		logic [1:0] part;
		logic tmo;
		logic [3:0] req;
		logic [1:0] io;
		logic [1:0] lvl;
		logic [5:0] rtype;
		logic [7:0] synd;
	} bel_err_info_t;
	// One-cycle error events from the bus unit
	typedef struct packed {
		logic hard;
		logic parity_fail;
		logic ecc_uncorr;
		logic ecc_corr;
	} bel_err_ev_t;
	// Bus clock to core clock ratio choices
	typedef enum logic [1:0] {
		BEL_DIV2,
		BEL_DIV3,
		BEL_DIV4
	} bel_ratio_t;
endpackage

// File: bel_tb.sv
// Self-checking testbench for the bus error status logger
`include "bel_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ****************************************
	// Shortened counts keep the timeout runs brief
	// ****************************************
	localparam int BD = 2;
	localparam int PB = 2;
	localparam int SB = 2;
	logic clock_i, arst_n_i, wr_i, rd_i, retire_i, exception_i, pin;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, d, lo;
	logic bus_clk_o, reinit, irq_o;
	bel_pkg::bel_err_ev_t ev;
	bel_pkg::bel_err_info_t info;
	int bad_count, total_checks, reinit_cnt, cyc, t0, n, div;
	bel_logger #(.BUS_DIV(BD), .PRE_BITS(PB), .STALL_BITS(SB)) bel_logger_i (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.retire_i(retire_i), .exception_i(exception_i),
		.internal_failure_pin_i(pin), .err_ev_i(ev), .err_info_i(info),
		.bus_clk_o(bus_clk_o), .bus_reinit_signal_o(reinit), .irq_o(irq_o));
	// Core clock at 250 MHz
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	// Cycle count and reinit pulse tally
	always @(posedge clock_i) begin
		cyc++;
		if (reinit === 1'b1) reinit_cnt++;
	end
	task automatic give_verdict;
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		d = rdata_o;
	endtask
	task automatic rdc(input string w, input logic [7:0] a,
		input logic [31:0] m, e);
		rd(a);
		chk(w, e, d & m);
	endtask
	task automatic fire(input bel_pkg::bel_err_ev_t e, input logic [7:0] s);
		@(posedge clock_i);
		ev <= e;
		info.synd <= s;
		@(posedge clock_i);
		ev <= '0;
	endtask
	task automatic irq_is(input logic e);
		@(negedge clock_i);
		chk("irq", {31'h0, e}, {31'h0, irq_o});
	endtask
	// Release retire and time the stall timeout for one bus ratio
	task automatic run_to(input int c, dv);
		wr(`BEL_OFS_CTRL, c);
		wr(`BEL_OFS_STAT_HI, 32'h0);
		reinit_cnt = 0;
		retire_i <= 1'b0;
		t0 = cyc;
		n = dv * BD * (1 << PB) * (1 << SB);
		do rd(`BEL_OFS_STAT_HI); while (d[6] !== 1'b1 && cyc - t0 < 600);
		@(posedge clock_i);
		retire_i <= 1'b1;
		t0 = cyc - t0 - 1;
		chk("timeout span", 1, (t0 >= n - 9 * dv - 2 && t0 <= n + 8));
		chk("reinit pulses", 1, reinit_cnt);
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock_i);
		bad_count++;
		$display("[FAIL] run time expected end seen hang");
		give_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{arst_n_i, wr_i, rd_i, exception_i, pin, addr_i, wdata_i} = '0;
		retire_i = 1'b1;
		ev = '0;
		info = '{2'b10, 1'b1, 4'hA, 2'b01, 2'b11, 6'h0C, 8'h00};
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		rdc("mask rst", `BEL_OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rdc("ctrl rst", `BEL_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rdc("stat hi rst", `BEL_OFS_STAT_HI, 32'hFFFFFFFF, 32'h0);
		@(negedge clock_i) chk("rdata idle", 32'h0, rdata_o);
		wr(8'h20, 32'h3);
		rdc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
		rdc("ctrl kept", `BEL_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		// ECC logging, syndrome freeze and release
		fire(4'b0001, 8'hA5);
		lo = {7'h0, info.rtype, 7'h0, 1'b1, info.part, info.tmo, info.req,
			info.io, info.lvl};
		rdc("code", `BEL_OFS_STAT_LO, 32'hFFFFFFFF, lo);
		rdc("ecc corr", `BEL_OFS_STAT_HI, 32'hFFFFFFFF,
			{1'b1, 8'h0, 8'hA5, 2'b10, 13'h0});
		fire(4'b0010, 8'h3C);
		rdc("ecc uncorr", `BEL_OFS_STAT_HI, 32'hFFFFFFFF,
			{2'b11, 7'h0, 8'h3C, 2'b11, 13'h0});
		fire(4'b0001, 8'h77);
		rdc("synd held", `BEL_OFS_STAT_HI, 32'hFFFFFFFF,
			{2'b11, 7'h0, 8'h3C, 2'b11, 13'h0});
		rdc("code held", `BEL_OFS_STAT_LO, 32'hFFFFFFFF, lo);
		wr(`BEL_OFS_STAT_HI, 32'hFFFFDFFF);
		fire(4'b0001, 8'h77);
		rdc("synd again", `BEL_OFS_STAT_HI, 32'hFFFFFFFF,
			{2'b11, 7'h0, 8'h77, 2'b10, 13'h0});
		wr(`BEL_OFS_STAT_LO, 32'h0);
		wr(`BEL_OFS_STAT_HI, 32'h0);
		rdc("lo clr", `BEL_OFS_STAT_LO, 32'hFFFFFFFF, 32'h0);
		rdc("hi clr", `BEL_OFS_STAT_HI, 32'hFFFFFFFF, 32'h0);
		// Hard error, paired parity failures, internal failure pin
		fire(4'b1000, 8'h00);
		rdc("hard", `BEL_OFS_STAT_HI, 32'h7C00, 32'h0400);
		fire(4'b0100, 8'h00);
		rdc("parity one", `BEL_OFS_STAT_HI, 32'h7C00, 32'h0400);
		fire(4'b0100, 8'h00);
		rdc("parity two", `BEL_OFS_STAT_HI, 32'h7C00, 32'h1400);
		@(posedge clock_i) pin <= 1'b1;
		repeat (8) @(posedge clock_i);
		pin <= 1'b0;
		rdc("internal_failure_pin", `BEL_OFS_STAT_HI, 32'h7C00, 32'h1C00);
		// Interrupt masking and read-to-clear
		irq_is(1'b0);
		wr(`BEL_OFS_IRQ_MASK, 32'h20);
		irq_is(1'b0);
		wr(`BEL_OFS_IRQ_MASK, 32'h10);
		irq_is(1'b1);
		rdc("irq stat", `BEL_OFS_IRQ_STAT, 32'h3F, 32'h1F);
		rdc("irq stat clr", `BEL_OFS_IRQ_STAT, 32'h3F, 32'h0);
		irq_is(1'b0);
		// Bus clock period for every ratio code
		for (int c = 0; c < 4; c++) begin
			div = (c == 0) ? 2 : (c == 1) ? 3 : 4;
			wr(`BEL_OFS_CTRL, c);
			repeat (8) @(posedge clock_i);
			@(posedge bus_clk_o) t0 = cyc;
			@(posedge bus_clk_o) chk("bus period", div, cyc - t0);
		end
		// Exceptions keep the stall counter from timing out
		wr(`BEL_OFS_CTRL, 32'h0);
		reinit_cnt = 0;
		retire_i <= 1'b0;
		repeat (6) begin
			repeat (30) @(posedge clock_i);
			exception_i <= 1'b1;
			@(posedge clock_i) exception_i <= 1'b0;
		end
		retire_i <= 1'b1;
		rdc("no timeout", `BEL_OFS_STAT_HI, 32'h40, 32'h0);
		chk("no reinit", 0, reinit_cnt);
		rdc("stall clr", `BEL_OFS_STALL, 32'hFFFFFFFF, 32'h0);
		// Timeout span per ratio, then sticky against a later error
		run_to(0, 2);
		run_to(1, 3);
		run_to(2, 4);
		fire(4'b1000, 8'h00);
		rdc("tmo held", `BEL_OFS_STAT_HI, 32'h440, 32'h440);
		give_verdict();
	end
endmodule
`default_nettype wire
